// >>> design/llfs_pkg.sv
// Purpose: Shared constants and carriers for the link loss fallback and status block.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes: Every offset, field position, reset value and count is named once here.
package llfs_pkg;
	localparam logic [7:0]  ADR_WEAR      = 8'h00;
	localparam logic [7:0]  ADR_SUPPLY    = 8'h04;
	localparam logic [7:0]  ADR_TIME      = 8'h08;
	localparam logic [7:0]  ADR_PROC_TEMP = 8'h0c;
	localparam logic [7:0]  ADR_SINK_TEMP = 8'h10;
	localparam logic [7:0]  ADR_CTRL      = 8'h14;
	localparam logic [7:0]  ADR_LOSS_LIM  = 8'h18;
	localparam logic [7:0]  ADR_RX_BASE   = 8'h40;
	localparam int          CTRL_FB_EN    = 0;
	localparam int          CTRL_SA_EN    = 1;
	localparam int          CTRL_CFG_OK   = 2;
	localparam int          SUP_VOLT_LSB  = 8;
	localparam logic [15:0] WEAR_UNKNOWN  = 16'hffff;
	localparam logic [15:0] WEAR_WARN     = 16'h005a;
	localparam logic [15:0] WEAR_END      = 16'h0064;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam logic [15:0] LOSS_LIM_RST  = 16'h0008;
	localparam int          RX_WORDS      = 4;
	localparam int          RX_AW         = 2;
	typedef struct packed {
		logic [15:0] wear;
		logic [7:0]  current;
		logic [7:0]  voltage;
		logic [15:0] proc_temp;
		logic [15:0] sink_temp;
	} llfs_meas_type;
	typedef struct packed {
		logic        valid;
		logic [RX_AW-1:0] idx;
		logic [31:0] data;
	} llfs_rx_type;
	typedef enum logic [1:0] {
		ST_RESET    = 2'b00,
		ST_ONLINE   = 2'b01,
		ST_FALLBACK = 2'b11,
		ST_DEFAULT  = 2'b10
	} llfs_state_type;
endpackage

// >>> design/llfs_rx_mem.sv
// Purpose: Small store for data words received from the controller.
// Assumes: One write port and one registered read port on one clock.
// Notes: A clear request zeroes every word; it wins over a write in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module llfs_rx_mem #(
	parameter int WORDS = 4,
	parameter int AW    = 2
) (
	// Clock and enable
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	input  wire logic          i_ce,
	// Write side
	input  wire logic          i_clr,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [31:0]   i_wdata,
	// Read side
	input  wire logic [AW-1:0] i_raddr,
	output logic      [31:0]   o_rdata
);
	logic [31:0] mem_ff [WORDS];
	logic [31:0] nxt_mem [WORDS];
	logic [31:0] rdata_ff;
	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			nxt_mem[i] = mem_ff[i];
			if (i_clr) begin
				nxt_mem[i] = 32'h0;
			end else if (i_we && (i_waddr == AW'(i))) begin
				nxt_mem[i] = i_wdata;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_ff[i] <= 32'h0;
			end
			rdata_ff <= 32'h0;
		end else if (i_ce) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_ff[i] <= nxt_mem[i];
			end
			rdata_ff <= mem_ff[i_raddr];
		end
	end
	assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> design/llfs_top.sv
// Purpose: Status reporting and link loss fallback control for an I/O module.
// Assumes: Single 50 MHz clock; measurement inputs come from logic on this clock.
// Notes: Registers sit on a classic Wishbone slave; acks come one cycle after a strobe.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module llfs_top #(
	parameter bit FB_SUPPORT  = 1'b1,
	parameter bit SA_SUPPORT  = 1'b1,
	parameter bit PROGRAMMABLE = 1'b1,
	parameter bit IS_COUPLER  = 1'b0,
	parameter bit TEMP_SIGNED = 1'b1
) (
	// Clock, reset, enable
	input  wire logic                   I_CLOCK,
	input  wire logic                   I_ARST_N,
	input  wire logic                   I_CE,
	// Wishbone slave
	input  wire logic                   I_WB_CYC,
	input  wire logic                   I_WB_STB,
	input  wire logic                   I_WB_WE,
	input  wire logic [7:0]             I_WB_ADR,
	input  wire logic [3:0]             I_WB_SEL,
	input  wire logic [31:0]            I_WB_DAT,
	output logic      [31:0]            O_WB_DAT,
	output logic                        O_WB_ACK,
	// Measurements
	input  wire llfs_pkg::llfs_meas_type I_MEAS,
	input  wire logic                   I_WEAR_VALID,
	input  wire logic [31:0]            I_USEC_TIME,
	input  wire logic                   I_TASK_START,
	// Link from the controller
	input  wire logic                   I_LINK_CYCLE,
	input  wire llfs_pkg::llfs_rx_type  I_RX,
	input  wire logic                   I_LOCAL_FB_ANY,
	// Function side
	input  wire logic [1:0]             I_RX_RD_IDX,
	output logic      [31:0]            O_RX_RD_DATA,
	output logic                        O_FUNC_RUN,
	output logic                        O_FUNC_DEFAULT,
	output logic                        O_MODULE_RESET
);
	logic [2:0]  ctrl_ff;
	logic [2:0]  nxt_ctrl;
	logic [15:0] loss_lim_ff;
	logic [15:0] nxt_loss_lim;
	logic [31:0] time_ff;
	logic [31:0] nxt_time;
	logic [15:0] miss_ff;
	logic [15:0] nxt_miss;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic        ack_ff;
	logic        nxt_ack;
	logic        started_ff;
	logic        nxt_started;
	logic        local_fb_meta_ff;
	logic        nxt_local_fb_meta;
	logic        local_fb_ff;
	logic        nxt_local_fb;
	llfs_pkg::llfs_state_type state_ff;
	llfs_pkg::llfs_state_type nxt_state;
	logic        fb_allowed;
	logic        sa_allowed;
	logic        link_lost;
	logic        clr_rx;
	logic [15:0] wear_code;
	logic        wb_req;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
	                                            input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Enable is ignored on parts without fallback support.
	assign fb_allowed = FB_SUPPORT && ctrl_ff[llfs_pkg::CTRL_FB_EN];
	// Standalone needs support, a saved configuration and, on a coupler, a local fallback module.
	assign sa_allowed = SA_SUPPORT && ctrl_ff[llfs_pkg::CTRL_SA_EN] && ctrl_ff[llfs_pkg::CTRL_CFG_OK]
	                    && fb_allowed && (!IS_COUPLER || local_fb_ff);
	assign link_lost  = (miss_ff >= loss_lim_ff);
	assign wb_req     = I_WB_CYC && I_WB_STB && !ack_ff;

	// The local fallback flag comes from backplane modules on their own clock, so it passes two flops.
	always_comb begin
		nxt_local_fb_meta = I_LOCAL_FB_ANY;
		nxt_local_fb      = local_fb_meta_ff;
	end

	// Wear is passed through; without condition data the all-ones code is shown.
	assign wear_code = I_WEAR_VALID ? I_MEAS.wear : llfs_pkg::WEAR_UNKNOWN;

	always_comb begin
		nxt_miss = miss_ff;
		if (I_RX.valid) begin
			nxt_miss = 16'h0;
		end else if (I_LINK_CYCLE && !link_lost) begin
			nxt_miss = miss_ff + 16'h1;
		end
	end

	always_comb begin
		nxt_state   = state_ff;
		nxt_started = started_ff || (state_ff != llfs_pkg::ST_RESET);
		case (state_ff)
			llfs_pkg::ST_RESET: begin
				// Standalone is checked while no controller was seen, so software can load saved settings first.
				if (!started_ff && sa_allowed) begin
					nxt_state = llfs_pkg::ST_FALLBACK;
				end else if (I_RX.valid) begin
					nxt_state = llfs_pkg::ST_ONLINE;
				end
			end
			llfs_pkg::ST_ONLINE: begin
				if (link_lost) begin
					nxt_state = fb_allowed ? llfs_pkg::ST_FALLBACK : llfs_pkg::ST_DEFAULT;
				end
			end
			llfs_pkg::ST_FALLBACK: begin
				// Rejoining keeps the function running, so outputs see no gap.
				if (I_RX.valid) begin
					nxt_state = llfs_pkg::ST_ONLINE;
				end
			end
			llfs_pkg::ST_DEFAULT: begin
				if (I_RX.valid) begin
					nxt_state = llfs_pkg::ST_ONLINE;
				end
			end
			default: begin
				nxt_state = llfs_pkg::ST_RESET;
			end
		endcase
	end

	// Received words are zeroed on fallback entry and on the default reset.
	assign clr_rx = (nxt_state == llfs_pkg::ST_FALLBACK && state_ff != llfs_pkg::ST_FALLBACK)
	                || (nxt_state == llfs_pkg::ST_DEFAULT && state_ff != llfs_pkg::ST_DEFAULT);

	always_comb begin
		nxt_time = time_ff;
		if (I_TASK_START) begin
			nxt_time = I_USEC_TIME;
		end
	end

	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_loss_lim = loss_lim_ff;
		nxt_ack      = wb_req;
		nxt_dat      = 32'h0;
		if (wb_req && I_WB_WE) begin
			case (I_WB_ADR)
				llfs_pkg::ADR_CTRL: begin
					nxt_ctrl = 3'(merge_bytes({29'h0, ctrl_ff}, I_WB_DAT, I_WB_SEL));
				end
				llfs_pkg::ADR_LOSS_LIM: begin
					nxt_loss_lim = 16'(merge_bytes({16'h0, loss_lim_ff}, I_WB_DAT, I_WB_SEL));
					if (nxt_loss_lim == 16'h0) begin
						nxt_loss_lim = 16'h1;
					end
				end
				default: begin
					nxt_ctrl = ctrl_ff;
				end
			endcase
		end else if (wb_req) begin
			// Temperatures are raw 16-bit codes; signedness depends on variant only.
			// The state register is never readable, so fallback stays hidden.
			case (I_WB_ADR)
				llfs_pkg::ADR_WEAR:      nxt_dat = {16'h0, wear_code};
				llfs_pkg::ADR_SUPPLY:    nxt_dat = {16'h0, I_MEAS.voltage, I_MEAS.current};
				llfs_pkg::ADR_TIME:      nxt_dat = time_ff;
				llfs_pkg::ADR_PROC_TEMP: nxt_dat = {16'h0, I_MEAS.proc_temp};
				llfs_pkg::ADR_SINK_TEMP: nxt_dat = {16'h0, I_MEAS.sink_temp};
				llfs_pkg::ADR_CTRL:      nxt_dat = {29'h0, ctrl_ff};
				llfs_pkg::ADR_LOSS_LIM:  nxt_dat = {16'h0, loss_lim_ff};
				default:                 nxt_dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctrl_ff     <= llfs_pkg::CTRL_RESET;
			loss_lim_ff <= llfs_pkg::LOSS_LIM_RST;
			time_ff     <= 32'h0;
			miss_ff     <= 16'h0;
			dat_ff      <= 32'h0;
			ack_ff      <= 1'b0;
			started_ff  <= 1'b0;
			state_ff    <= llfs_pkg::ST_RESET;
			local_fb_meta_ff <= 1'b0;
			local_fb_ff      <= 1'b0;
		end else if (I_CE) begin
			ctrl_ff     <= nxt_ctrl;
			loss_lim_ff <= nxt_loss_lim;
			time_ff     <= nxt_time;
			miss_ff     <= nxt_miss;
			dat_ff      <= nxt_dat;
			ack_ff      <= nxt_ack;
			started_ff  <= nxt_started;
			state_ff    <= nxt_state;
			local_fb_meta_ff <= nxt_local_fb_meta;
			local_fb_ff      <= nxt_local_fb;
		end
	end

	llfs_rx_mem #(
		.WORDS (llfs_pkg::RX_WORDS),
		.AW    (llfs_pkg::RX_AW)
	) u_rx_mem (
		.i_clk    (I_CLOCK),
		.i_arst_n (I_ARST_N),
		.i_ce     (I_CE),
		.i_clr    (clr_rx),
		.i_we     (I_RX.valid),
		.i_waddr  (I_RX.idx),
		.i_wdata  (I_RX.data),
		.i_raddr  (I_RX_RD_IDX),
		.o_rdata  (O_RX_RD_DATA)
	);

	assign O_WB_DAT       = dat_ff;
	assign O_WB_ACK       = ack_ff;
	// Function runs online and in fallback; a standard module runs defaults in fallback.
	assign O_FUNC_RUN     = (state_ff == llfs_pkg::ST_ONLINE) || (state_ff == llfs_pkg::ST_FALLBACK);
	assign O_FUNC_DEFAULT = (state_ff == llfs_pkg::ST_DEFAULT)
	                        || (!PROGRAMMABLE && state_ff == llfs_pkg::ST_FALLBACK);
	assign O_MODULE_RESET = (state_ff == llfs_pkg::ST_ONLINE) && link_lost && !fb_allowed;

	ack_one_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && O_WB_ACK |=> !O_WB_ACK || !I_CE)
		else $error("ack held longer than one cycle");
	ack_next_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req |=> O_WB_ACK)
		else $error("request not acknowledged in the next cycle");
	wr_dat_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && I_WB_WE |=> O_WB_DAT == 32'h0)
		else $error("write returned nonzero data");
	ce_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		!I_CE |=> state_ff == $past(state_ff) && miss_ff == $past(miss_ff) && time_ff == $past(time_ff))
		else $error("state moved while enable was low");

	fb_entry_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_ONLINE && link_lost && fb_allowed |=> state_ff == llfs_pkg::ST_FALLBACK)
		else $error("fallback not entered on link loss");
	no_fb_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_ONLINE && link_lost && !fb_allowed |=> state_ff == llfs_pkg::ST_DEFAULT)
		else $error("default state not entered on link loss");
	unsup_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff != llfs_pkg::ST_FALLBACK && nxt_state == llfs_pkg::ST_FALLBACK
		|-> FB_SUPPORT && ctrl_ff[llfs_pkg::CTRL_FB_EN])
		else $error("fallback without support");
	sa_entry_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_RESET && !started_ff && sa_allowed |=> state_ff == llfs_pkg::ST_FALLBACK)
		else $error("standalone start not taken");
	fb_func_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_ONLINE && link_lost && fb_allowed
		|=> O_FUNC_RUN && (O_FUNC_DEFAULT == !PROGRAMMABLE))
		else $error("function behaviour wrong in fallback");
	reset_pulse_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && O_MODULE_RESET |=> O_FUNC_DEFAULT && !O_MODULE_RESET)
		else $error("module reset not followed by defaults");
	rejoin_def_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_DEFAULT && I_RX.valid |=> state_ff == llfs_pkg::ST_ONLINE)
		else $error("no rejoin from default operation");
	rx_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && clr_rx ##1 I_CE |=> O_RX_RD_DATA == 32'h0)
		else $error("received words not zeroed");

	rejoin_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_FALLBACK && I_RX.valid |=> state_ff == llfs_pkg::ST_ONLINE && O_FUNC_RUN)
		else $error("no bumpless rejoin");
	wear_code_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_WEAR && !I_WEAR_VALID
		|=> O_WB_DAT == 32'h0000ffff)
		else $error("wear unknown code wrong");
	wear_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_WEAR && I_WEAR_VALID
		|=> O_WB_DAT == {16'h0, $past(I_MEAS.wear)})
		else $error("wear value not passed through");
	supply_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_SUPPLY
		|=> O_WB_DAT == {16'h0, $past(I_MEAS.voltage), $past(I_MEAS.current)})
		else $error("supply word wrong");
	time_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_TIME |=> O_WB_DAT == $past(time_ff))
		else $error("task time read wrong");
	temp_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_PROC_TEMP |=> O_WB_DAT == {16'h0, $past(I_MEAS.proc_temp)})
		else $error("processor temperature read wrong");
	sink_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && wb_req && !I_WB_WE && I_WB_ADR == llfs_pkg::ADR_SINK_TEMP |=> O_WB_DAT == {16'h0, $past(I_MEAS.sink_temp)})
		else $error("heat sink temperature read wrong");

	time_latch_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && I_TASK_START |=> time_ff == $past(I_USEC_TIME))
		else $error("task time not latched");
	miss_cnt_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && I_RX.valid |=> miss_ff == 16'h0)
		else $error("miss count not cleared by frame");
	lim_floor_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		loss_lim_ff != 16'h0)
		else $error("loss limit reached zero");
	miss_step_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && I_LINK_CYCLE && !I_RX.valid && !link_lost |=> miss_ff == $past(miss_ff) + 16'h1)
		else $error("miss count did not step");
	miss_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && link_lost && !I_RX.valid |=> miss_ff == $past(miss_ff))
		else $error("miss count moved after link loss");

	sa_start_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		I_CE && state_ff == llfs_pkg::ST_RESET && !ctrl_ff[llfs_pkg::CTRL_CFG_OK] && !I_RX.valid
		|=> state_ff == llfs_pkg::ST_RESET)
		else $error("standalone start without configuration");
	fb_cov: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) state_ff == llfs_pkg::ST_FALLBACK);
	def_cov: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) state_ff == llfs_pkg::ST_DEFAULT);
	back_cov: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		state_ff == llfs_pkg::ST_FALLBACK ##1 state_ff == llfs_pkg::ST_ONLINE);
	sa_cov: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		state_ff == llfs_pkg::ST_RESET ##1 state_ff == llfs_pkg::ST_FALLBACK);
	rst_cov: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) O_MODULE_RESET);
endmodule
`default_nettype wire

// >>> tb/llfs_ctrl_model.sv
// Purpose: Behavioural higher-level controller that sends one frame word per link cycle.
// Assumes: Frames are sent only while i_online is high.
// Notes: A released data line flips between its last word and that word's inverse every clock, so stale data never looks fresh.
`timescale 1ns/10ps
`default_nettype none
module llfs_ctrl_model #(
	parameter int PERIOD = 4
) (
	// Clock and control
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_online,
	// Link
	output var logic              o_link_cycle,
	output var llfs_pkg::llfs_rx_type o_rx
);
	logic [7:0]  tick;
	logic [31:0] seq;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick <= 8'h00;
			seq <= 32'h00000000;
			o_link_cycle <= 1'b0;
			o_rx <= '0;
		end else begin
			tick <= (tick == 8'(PERIOD - 1)) ? 8'h00 : tick + 8'h01;
			o_link_cycle <= (tick == 8'h00);
			o_rx.valid <= i_online && (tick == 8'h00);
			if (i_online && tick == 8'h00) begin
				seq <= seq + 32'h00000001;
				o_rx.idx <= seq[1:0];
				o_rx.data <= {seq[15:0] + 16'h0001, ~seq[15:0]};
			end else begin
				o_rx.data <= ~o_rx.data;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/link_loss_fallback_status_tb.sv
// Purpose: Self-checking bench for status registers and link loss fallback.
// Assumes: Wishbone acks one cycle after a strobe; link cycle every four clocks.
// Notes: Fallback is only visible through zeroed receive words, never through a flag.
`timescale 1ns/10ps
`default_nettype none
module link_loss_fallback_status_tb;
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  ce = 1'b1;
	logic                  cyc = 1'b0;
	logic                  stb = 1'b0;
	logic                  we = 1'b0;
	logic [7:0]            adr = 8'h00;
	logic [31:0]           wdat = 32'h00000000;
	logic [31:0]           rdat;
	logic                  ack;
	llfs_pkg::llfs_meas_type meas = '0;
	logic                  wear_ok = 1'b0;
	logic [31:0]           usec = 32'h00000000;
	logic                  task_go = 1'b0;
	logic                  online = 1'b0;
	logic                  link_cyc;
	llfs_pkg::llfs_rx_type rx;
	logic [1:0]            rd_idx = 2'h0;
	logic [31:0]           rxd;
	logic                  run;
	logic                  dflt;
	logic                  mrst;
	int                    errors = 0;
	int                    n_checks = 0;
	int                    cycles = 0;
	int                    resets = 0;
	int                    run_drops = 0;
	bit                    watch = 1'b0;
	logic [15:0]           rnd = 16'h6c87;
	logic [31:0]           q;
	logic [31:0]           last_rx [4];
	logic [15:0]           corner [4] = '{16'h0000, llfs_pkg::WEAR_WARN, llfs_pkg::WEAR_END, 16'h0065};

	llfs_top dut_u (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_MEAS(meas), .I_WEAR_VALID(wear_ok), .I_USEC_TIME(usec), .I_TASK_START(task_go),
		.I_LINK_CYCLE(link_cyc), .I_RX(rx), .I_LOCAL_FB_ANY(1'b0), .I_RX_RD_IDX(rd_idx),
		.O_RX_RD_DATA(rxd), .O_FUNC_RUN(run), .O_FUNC_DEFAULT(dflt), .O_MODULE_RESET(mrst));
	llfs_ctrl_model ctrl_u (.i_clk(clk), .i_arst_n(arst_n), .i_online(online), .o_link_cycle(link_cyc), .o_rx(rx));

	always #10 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (mrst === 1'b1) resets++;
		if (watch && run !== 1'b1) run_drops++;
		if (rx.valid === 1'b1) last_rx[rx.idx] <= rx.data;
		if (cycles > 20000) begin
			errors++;
			results();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] exp_wear(input logic v, input logic [15:0] w);
		return v ? w : llfs_pkg::WEAR_UNKNOWN;
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Holds the request until ack is sampled high, then idles one cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) chk("wb ack", 32'h1, {31'h0, ack});
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rxrd(input bit zero);
		for (int i = 0; i < 4; i++) begin
			rd_idx <= 2'(i);
			repeat (2) @(posedge clk);
			chk("rx word", zero ? 32'h00000000 : last_rx[i], rxd);
		end
	endtask

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, llfs_pkg::ADR_CTRL, 32'h0, q);
		chk("ctrl reset", 32'h0, q);
		wb(1'b0, llfs_pkg::ADR_LOSS_LIM, 32'h0, q);
		chk("limit reset", 32'h8, q);
		wb(1'b0, 8'h3c, 32'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1'b1, llfs_pkg::ADR_LOSS_LIM, 32'h0, q);
		wb(1'b0, llfs_pkg::ADR_LOSS_LIM, 32'h0, q);
		chk("limit floor", 32'h1, q);
		ce <= 1'b0;
		usec <= 32'h5a5aa5a5;
		task_go <= 1'b1;
		@(posedge clk);
		ce <= 1'b1;
		task_go <= 1'b0;
		wb(1'b0, llfs_pkg::ADR_TIME, 32'h0, q);
		chk("ce freeze", 32'h0, q);
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			meas.wear <= (i < 4) ? corner[i] : rnd;
			meas.current <= rnd[7:0];
			meas.voltage <= rnd[15:8] ^ 8'h3c;
			meas.proc_temp <= ~rnd;
			meas.sink_temp <= {rnd[7:0], rnd[15:8]};
			wear_ok <= (i != 5);
			usec <= {rnd, ~rnd};
			task_go <= 1'b1;
			@(posedge clk);
			task_go <= 1'b0;
			usec <= {~rnd, rnd};
			wb(1'b1, llfs_pkg::ADR_WEAR, 32'h1234, q);
			wb(1'b0, llfs_pkg::ADR_WEAR, 32'h0, q);
			chk("wear", {16'h0, exp_wear(i != 5, meas.wear)}, {16'h0, q[15:0]});
			wb(1'b0, llfs_pkg::ADR_SUPPLY, 32'h0, q);
			chk("supply", {16'h0, meas.voltage, meas.current}, {16'h0, q[15:0]});
			wb(1'b0, llfs_pkg::ADR_TIME, 32'h0, q);
			chk("time", {rnd, ~rnd}, q);
			wb(1'b0, llfs_pkg::ADR_PROC_TEMP, 32'h0, q);
			chk("proc temp", {16'h0, ~rnd}, {16'h0, q[15:0]});
			wb(1'b0, llfs_pkg::ADR_SINK_TEMP, 32'h0, q);
			chk("sink temp", {16'h0, rnd[7:0], rnd[15:8]}, {16'h0, q[15:0]});
		end
		$display("test status done");
		wb(1'b1, llfs_pkg::ADR_LOSS_LIM, 32'h10, q);
		wb(1'b1, llfs_pkg::ADR_CTRL, 32'h5, q);
		online <= 1'b1;
		repeat (30) @(posedge clk);
		chk("run online", 32'h1, {31'h0, run});
		watch <= 1'b1;
		online <= 1'b0;
		repeat (2) @(posedge clk);
		rxrd(1'b0);
		repeat (80) @(posedge clk);
		rxrd(1'b1);
		chk("fallback default", 32'h0, {31'h0, dflt});
		chk("fallback resets", 32'h0, resets);
		online <= 1'b1;
		repeat (30) @(posedge clk);
		watch <= 1'b0;
		chk("run drops", 32'h0, run_drops);
		$display("test fallback done");
		wb(1'b1, llfs_pkg::ADR_CTRL, 32'h4, q);
		online <= 1'b0;
		repeat (90) @(posedge clk);
		chk("module resets", 32'h1, resets);
		chk("run default", 32'h0, {31'h0, run});
		chk("default on", 32'h1, {31'h0, dflt});
		rxrd(1'b1);
		online <= 1'b1;
		repeat (30) @(posedge clk);
		chk("run back", 32'h1, {31'h0, run});
		chk("default off", 32'h0, {31'h0, dflt});
		$display("test default done");
		online <= 1'b0;
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		wb(1'b1, llfs_pkg::ADR_CTRL, 32'h3, q);
		repeat (8) @(posedge clk);
		chk("no saved config", 32'h0, {31'h0, run});
		wb(1'b1, llfs_pkg::ADR_CTRL, 32'h7, q);
		repeat (2) @(posedge clk);
		chk("standalone run", 32'h1, {31'h0, run});
		rxrd(1'b1);
		online <= 1'b1;
		repeat (30) @(posedge clk);
		chk("standalone rejoin", 32'h1, {31'h0, run});
		$display("test standalone done");
		results();
	end
endmodule
`default_nettype wire
